// ---- hw/gfs_pkg.sv ----
// Constants shared by the pin output-function selector
package gfs_pkg;
	// ****************************************
	// Widths
	// ****************************************
	localparam int PIN_N   = 16;
	localparam int LOW_N   = 8;
	localparam int FUNC_W  = 10;
	localparam int EVT_N   = 6;
	localparam int DIV_W   = 8;
	localparam int DUR_W   = 8;

	// ****************************************
	// Function codes
	// ****************************************
	localparam logic [FUNC_W-1:0] FN_GPIO   = 10'h001;
	localparam logic [FUNC_W-1:0] FN_INTERRUPT_REQUEST_ONE   = 10'h003;
	localparam logic [FUNC_W-1:0] FN_FLLCLK = 10'h010;
	localparam logic [FUNC_W-1:0] FN_LOCK   = 10'h018;
	localparam logic [FUNC_W-1:0] FN_DERIVED_OUTPUT_CLOCK  = 10'h048;
	localparam logic [FUNC_W-1:0] FN_PULSE_WIDTH_OUT_ONE   = 10'h080;
	localparam logic [FUNC_W-1:0] FN_PULSE_WIDTH_OUT_TWO   = 10'h081;
	localparam logic [FUNC_W-1:0] FN_SIGDET = 10'h08C;
	localparam logic [FUNC_W-1:0] FN_US1    = 10'h090;
	localparam logic [FUNC_W-1:0] FN_US2    = 10'h092;
	localparam logic [FUNC_W-1:0] FN_EVLOG  = 10'h158;
	localparam logic [FUNC_W-1:0] FN_ALM1   = 10'h230;
	localparam logic [FUNC_W-1:0] FN_ALM4   = 10'h233;
	localparam logic [FUNC_W-1:0] FN_TMR1   = 10'h250;
	localparam logic [FUNC_W-1:0] FN_TMR2   = 10'h251;

	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [11:0] OFS_FUNC0  = 12'h000;
	localparam logic [11:0] OFS_DIR    = 12'h040;
	localparam logic [11:0] OFS_LVL    = 12'h044;
	localparam logic [11:0] OFS_PIN_IN = 12'h048;
	localparam logic [11:0] OFS_DIV    = 12'h04C;
	localparam logic [11:0] OFS_DUR    = 12'h050;
	localparam logic [11:0] OFS_STAT   = 12'h054;
	localparam logic [11:0] OFS_MASK   = 12'h058;

	// ****************************************
	// Reset values and fixed timer pulse length
	// ****************************************
	localparam logic [FUNC_W-1:0] RST_FUNC = FN_GPIO;
	localparam logic [PIN_N-1:0]  RST_DIR  = 16'hFFFF;
	localparam logic [PIN_N-1:0]  RST_LVL  = 16'h0000;
	localparam logic [DIV_W-1:0]  RST_DIV  = 8'h01;
	localparam logic [DUR_W-1:0]  RST_DUR  = 8'h01;
	localparam logic [EVT_N-1:0]  RST_MASK = 6'h00;
	localparam logic [DUR_W-1:0]  TMR_DUR  = 8'h01;
endpackage : gfs_pkg

// ---- hw/gfs_clk_div.sv ----
// Divider making the derived output clock from the system clock
`timescale 1ns/100ps
`default_nettype none
module gfs_clk_div
	import gfs_pkg::*;
#(
	parameter int W = DIV_W
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] half_cnt,
	output logic              clk_out
);
	logic [W-1:0] cnt_r;
	logic         clk_r;
	wire          wrap = (cnt_r + W'(1)) >= half_cnt;

	if (W < 1) begin : g_bad_w
		$error("gfs_clk_div: width too small");
	end

	// Half period of half_cnt cycles, zero counts as one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= '0;
			clk_r <= 1'b0;
		end else if (wrap) begin
			cnt_r <= '0;
			clk_r <= ~clk_r;
		end else begin
			cnt_r <= cnt_r + W'(1);
		end
	end

	assign clk_out = clk_r;
endmodule // gfs_clk_div
`default_nettype wire

// ---- hw/gfs_pulse_gen.sv ----
// Pulse of programmable length started by a trigger
`timescale 1ns/100ps
`default_nettype none
module gfs_pulse_gen
	import gfs_pkg::*;
#(
	parameter int W = DUR_W
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         trig,
	input  wire logic [W-1:0] dur,
	output logic              pulse
);
	logic [W-1:0] left_r;
	wire  [W-1:0] len = (dur == '0) ? W'(1) : dur;

	if (W < 1) begin : g_bad_w
		$error("gfs_pulse_gen: width too small");
	end

	// A fresh trigger restarts the pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left_r <= '0;
		end else if (trig) begin
			left_r <= len;
		end else if (left_r != '0) begin
			left_r <= left_r - W'(1);
		end
	end

	assign pulse = (left_r != '0);
endmodule // gfs_pulse_gen
`default_nettype wire

// ---- hw/gfs_top.sv ----
// Pin output-function selector with APB registers and interrupt
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// RULE1: code 0x010 on pins 1-8 drives the loop output clock.
// RULE2: code 0x018 on pins 1-8 drives loop lock, high when locked.
// RULE3: code 0x048 on pins 1-8 drives a divided system clock.
// RULE4: code 0x080 drives the first PWM output on any pin.
// RULE5: code 0x081 drives the second PWM output on any pin.
// RULE6: code 0x08C on pins 1-8 drives the signal-detect flag.
// RULE7: code 0x090 on pins 1-8 drives ultrasonic detector one flag.
// RULE8: code 0x092 on pins 1-8 drives ultrasonic detector two flag.
// RULE9: code 0x158 on pins 1-8 drives event-log FIFO not-empty.
// RULE10: codes 0x230-0x233 drive alarm pulses of programmable length.
// RULE11: codes 0x250/0x251 drive a pulse when a timer completes.
// RULE12: code 0x003 on pins 1-8 drives the interrupt request one line.
// RULE13: code 0x001 as output drives the pin output level setting.
// RULE14: a pins-1-8 function on pins 9-16 drives the pin low.
module gfs_top
	import gfs_pkg::*;
#(
	parameter int PINS = PIN_N
) (
	input  wire logic            pclk,
	input  wire logic            presetn,
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [11:0]     paddr,
	input  wire logic [31:0]     pwdata,
	output logic      [31:0]     prdata,
	output logic                 pready,
	output logic                 pslverr,
	input  wire logic            freq_locked_loop_one_clk,
	input  wire logic            freq_locked_loop_one_lock,
	input  wire logic            pulse_width_out_one,
	input  wire logic            pulse_width_out_two,
	input  wire logic            signal_detect,
	input  wire logic            ultrasonic_detector_one,
	input  wire logic            ultrasonic_detector_two,
	input  wire logic            event_log_not_empty,
	input  wire logic            interrupt_request_one,
	input  wire logic [3:0]      alarm_trigger,
	input  wire logic [1:0]      timer_done,
	input  wire logic [PINS-1:0] pin_in,
	output logic      [PINS-1:0] pin_out,
	output logic      [PINS-1:0] pin_oe,
	output logic                 irq
);
	if (PINS != PIN_N) begin : g_bad_pins
		$error("gfs_top: only 16 pins supported");
	end

	// ****************************************
	// Decode helpers
	// ****************************************
	function automatic logic gfs_low_only(input logic [FUNC_W-1:0] c);
		return (c == FN_INTERRUPT_REQUEST_ONE) || (c == FN_FLLCLK) || (c == FN_LOCK) ||
		       (c == FN_DERIVED_OUTPUT_CLOCK) || (c == FN_SIGDET) || (c == FN_US1) ||
		       (c == FN_US2) || (c == FN_EVLOG);
	endfunction

	function automatic logic gfs_is_clk(input logic [FUNC_W-1:0] c);
		return (c == FN_FLLCLK) || (c == FN_DERIVED_OUTPUT_CLOCK);
	endfunction

	function automatic logic gfs_known(input logic [FUNC_W-1:0] c);
		return gfs_low_only(c) || (c == FN_GPIO) || (c == FN_PULSE_WIDTH_OUT_ONE) ||
		       (c == FN_PULSE_WIDTH_OUT_TWO) || ((c >= FN_ALM1) && (c <= FN_ALM4)) ||
		       (c == FN_TMR1) || (c == FN_TMR2);
	endfunction

	// Level source bundle: 0 irq,1 lock,2-3 pwm,4 sd,5-6 us,7 log,
	// 8-11 alarms, 12-13 timers
	function automatic logic gfs_pick(input logic [FUNC_W-1:0] c,
	                                  input logic [13:0] s,
	                                  input logic lvl);
		logic r;
		r = 1'b0;
		case (c)
			FN_GPIO:   r = lvl;    // RULE13
			FN_INTERRUPT_REQUEST_ONE:   r = s[0];   // RULE12
			FN_LOCK:   r = s[1];   // RULE2
			FN_PULSE_WIDTH_OUT_ONE:   r = s[2];   // RULE4
			FN_PULSE_WIDTH_OUT_TWO:   r = s[3];   // RULE5
			FN_SIGDET: r = s[4];   // RULE6
			FN_US1:    r = s[5];   // RULE7
			FN_US2:    r = s[6];   // RULE8
			FN_EVLOG:  r = s[7];   // RULE9
			FN_TMR1:   r = s[12];  // RULE11
			FN_TMR2:   r = s[13];  // RULE11
			default: begin
				if ((c >= FN_ALM1) && (c <= FN_ALM4))
					r = s[4'd8 + 4'(c - FN_ALM1)];  // RULE10
			end
		endcase
		return r;
	endfunction

	// ****************************************
	// Registers
	// ****************************************
	logic [FUNC_W-1:0] func_r [PINS];
	logic [PINS-1:0]   dir_r;
	logic [PINS-1:0]   lvl_r;
	logic [DIV_W-1:0]  div_r;
	logic [DUR_W-1:0]  dur_r;
	logic [EVT_N-1:0]  stat_r;
	logic [EVT_N-1:0]  mask_r;
	logic [PINS-1:0]   pin_q_r;
	logic [EVT_N-1:0]  stat_nxt;

	wire        acc     = psel && penable;
	wire        wr      = acc && pwrite;
	wire [11:0] wa      = {paddr[11:2], 2'b00};
	wire [11:0] fn_ofs  = wa - OFS_FUNC0;
	wire        hit_fn  = (fn_ofs < (OFS_DIR - OFS_FUNC0));
	wire [3:0]  fn_idx  = fn_ofs[5:2];
	wire        hit_dir = (wa == OFS_DIR);
	wire        hit_lvl = (wa == OFS_LVL);
	wire        hit_in  = (wa == OFS_PIN_IN);
	wire        hit_div = (wa == OFS_DIV);
	wire        hit_dur = (wa == OFS_DUR);
	wire        hit_st  = (wa == OFS_STAT);
	wire        hit_msk = (wa == OFS_MASK);
	wire        mapped  = hit_fn || hit_dir || hit_lvl || hit_in ||
	                      hit_div || hit_dur || hit_st || hit_msk;

	// ****************************************
	// APB slave, zero wait states
	// ****************************************
	assign pready  = 1'b1;
	assign pslverr = acc && !mapped;

	wire [31:0] rd_mux =
		hit_fn  ? {22'h00_0000, func_r[fn_idx]} :
		hit_dir ? {16'h0000, dir_r} :
		hit_lvl ? {16'h0000, lvl_r} :
		hit_in  ? {16'h0000, pin_in} :
		hit_div ? {24'h00_0000, div_r} :
		hit_dur ? {24'h00_0000, dur_r} :
		hit_st  ? {26'h000_0000, stat_r} :
		hit_msk ? {26'h000_0000, mask_r} : 32'h0000_0000;

	assign prdata = rd_mux;

	genvar gi;
	generate
		for (gi = 0; gi < PINS; gi++) begin : g_func
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					func_r[gi] <= RST_FUNC;
				else if (wr && hit_fn && (fn_idx == 4'(gi)))
					func_r[gi] <= pwdata[FUNC_W-1:0];
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dir_r  <= RST_DIR;
			lvl_r  <= RST_LVL;
			div_r  <= RST_DIV;
			dur_r  <= RST_DUR;
			mask_r <= RST_MASK;
		end else if (wr) begin
			if (hit_dir) dir_r <= pwdata[PINS-1:0];
			if (hit_lvl) lvl_r <= pwdata[PINS-1:0];
			if (hit_div) div_r <= pwdata[DIV_W-1:0];
			if (hit_dur) dur_r <= pwdata[DUR_W-1:0];
			if (hit_msk) mask_r <= pwdata[EVT_N-1:0];
		end
	end

	// ****************************************
	// Event pulses and interrupt
	// ****************************************
	logic [3:0] alarm_pulse;
	logic [1:0] timer_pulse;
	logic       derived_output_clock;

	generate
		for (gi = 0; gi < 4; gi++) begin : g_alarm
			gfs_pulse_gen #(.W(DUR_W)) u_alm (
				.pclk    (pclk),
				.presetn (presetn),
				.trig    (alarm_trigger[gi]),
				.dur     (dur_r),
				.pulse   (alarm_pulse[gi])
			);  // RULE10
		end
		for (gi = 0; gi < 2; gi++) begin : g_timer
			gfs_pulse_gen #(.W(DUR_W)) u_tmr (
				.pclk    (pclk),
				.presetn (presetn),
				.trig    (timer_done[gi]),
				.dur     (TMR_DUR),
				.pulse   (timer_pulse[gi])
			);  // RULE11
		end
	endgenerate

	gfs_clk_div #(.W(DIV_W)) u_derived_output_clock (
		.pclk     (pclk),
		.presetn  (presetn),
		.half_cnt (div_r),
		.clk_out  (derived_output_clock)
	);  // RULE3

	// Set wins over a write-one clear in the same cycle
	wire [EVT_N-1:0] evt = {timer_done, alarm_trigger};
	wire [EVT_N-1:0] clr = (wr && hit_st) ? pwdata[EVT_N-1:0] : '0;
	assign stat_nxt = (stat_r & ~clr) | evt;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			stat_r <= '0;
		else
			stat_r <= stat_nxt;
	end

	assign irq = |(stat_r & mask_r);

	// ****************************************
	// Pin routing
	// ****************************************
	wire [13:0] src = {timer_pulse, alarm_pulse, event_log_not_empty,
	                   ultrasonic_detector_two, ultrasonic_detector_one,
	                   signal_detect, pulse_width_out_two,
	                   pulse_width_out_one, freq_locked_loop_one_lock,
	                   interrupt_request_one};

	generate
		for (gi = 0; gi < PINS; gi++) begin : g_pin
			wire [FUNC_W-1:0] code    = func_r[gi];
			wire              blocked = gfs_low_only(code) && (gi >= LOW_N);
			wire              pick    = gfs_pick(code, src, lvl_r[gi]);
			wire              clk_src = (code == FN_FLLCLK) ?
			                            freq_locked_loop_one_clk :  // RULE1
			                            derived_output_clock;                      // RULE3
			wire              is_clk  = gfs_is_clk(code) && !blocked;

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					pin_q_r[gi] <= 1'b0;
				else
					pin_q_r[gi] <= pick && !blocked;  // RULE14
			end

			assign pin_out[gi] = is_clk ? clk_src : pin_q_r[gi];
			assign pin_oe[gi]  = (code == FN_GPIO) ? !dir_r[gi] :
			                     gfs_known(code);  // RULE13
		end
	endgenerate
endmodule // gfs_top
`default_nettype wire

// ---- verif/gfs_props.sv ----
// Checker of pin routing, APB answer and interrupt gating
`timescale 1ns/100ps
`default_nettype none
module gfs_props
	import gfs_pkg::*;
#(
	parameter int PINS = PIN_N
) (
	input wire logic            pclk,
	input wire logic            presetn,
	input wire logic            psel,
	input wire logic            penable,
	input wire logic            pwrite,
	input wire logic [11:0]     paddr,
	input wire logic [31:0]     pwdata,
	input wire logic            pready,
	input wire logic            pslverr,
	input wire logic            freq_locked_loop_one_clk,
	input wire logic            freq_locked_loop_one_lock,
	input wire logic            pulse_width_out_one,
	input wire logic            ultrasonic_detector_one,
	input wire logic            interrupt_request_one,
	input wire logic [PINS-1:0] pin_out,
	input wire logic [PINS-1:0] pin_oe,
	input wire logic            irq
);
	// ****
	// Shadow of pin 1 and pin 9 codes and of the mask
	// ****
	logic [FUNC_W-1:0] f1_r;
	logic [FUNC_W-1:0] f9_r;
	logic [EVT_N-1:0]  msk_r;
	wire               wr = psel && penable && pwrite;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			f1_r  <= RST_FUNC;
			f9_r  <= RST_FUNC;
			msk_r <= RST_MASK;
		end else if (wr) begin
			if (paddr == OFS_FUNC0) f1_r <= pwdata[FUNC_W-1:0];
			if (paddr == 12'h020) f9_r <= pwdata[FUNC_W-1:0];
			if (paddr == OFS_MASK) msk_r <= pwdata[EVT_N-1:0];
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ****
	// Properties
	// ****
	property p_rdy; psel && penable |-> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("pready low");
	property p_err; psel && penable && {paddr[11:2], 2'b00} > OFS_MASK
		|-> pslverr; endproperty
	a_err: assert property (p_err) else $error("no slave error");
	property p_clk;
		f1_r == FN_FLLCLK |-> pin_out[0] == freq_locked_loop_one_clk;
	endproperty
	a_clk: assert property (p_clk) else $error("loop clock");
	property p_lock; (f1_r == FN_LOCK) [*2]
		|-> pin_out[0] == $past(freq_locked_loop_one_lock); endproperty
	a_lock: assert property (p_lock) else $error("lock flag");
	property p_us1; f1_r == FN_US1 && $past(f1_r) == FN_US1
		|-> pin_out[0] == $past(ultrasonic_detector_one); endproperty
	a_us1: assert property (p_us1) else $error("detector flag");
	property p_interrupt_request_one; (f1_r == FN_INTERRUPT_REQUEST_ONE) [*2]
		|-> pin_out[0] == $past(interrupt_request_one); endproperty
	a_interrupt_request_one: assert property (p_interrupt_request_one) else $error("request line");
	property p_pwm; (f9_r == FN_PULSE_WIDTH_OUT_ONE) [*2]
		|-> pin_out[8] == $past(pulse_width_out_one); endproperty
	a_pwm: assert property (p_pwm) else $error("pwm on pin 9");
	property p_low; $past(f9_r) == FN_LOCK && f9_r == FN_LOCK
		|-> !pin_out[8] && pin_oe[8]; endproperty
	a_low: assert property (p_low) else $error("pin 9 not low");
	property p_msk; msk_r == '0 |-> !irq; endproperty
	a_msk: assert property (p_msk) else $error("masked irq");
endmodule // gfs_props
bind gfs_top gfs_props #(.PINS(PINS)) u_props (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
	.freq_locked_loop_one_clk, .freq_locked_loop_one_lock,
	.pulse_width_out_one, .ultrasonic_detector_one,
	.interrupt_request_one, .pin_out, .pin_oe, .irq);
`default_nettype wire

// ---- verif/gfs_board.sv ----
// Board model reading the pins back
`timescale 1ns/100ps
`default_nettype none
module gfs_board
	import gfs_pkg::*;
(
	input  wire logic [PIN_N-1:0] pin_out,
	input  wire logic [PIN_N-1:0] pin_oe,
	output logic      [PIN_N-1:0] pin_in
);
	// Released pins fall to the board pull-downs
	assign pin_in = pin_out & pin_oe;
endmodule // gfs_board
`default_nettype wire

// ---- verif/gfs_top_tb.sv ----
// Self-checking testbench of the pin output-function selector
`timescale 1ns/100ps
`default_nettype none
module gfs_top_tb;
	import gfs_pkg::*;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        fclk;
	logic [7:0]  lv;
	logic [3:0]  alm;
	logic [1:0]  tmr;
	logic [15:0] pin_in;
	logic [15:0] pin_out;
	logic [15:0] pin_oe;
	logic        irq;
	logic [31:0] rd;
	logic        se;
	logic [15:0] v;
	int          n_errors;
	int          n_tests;
	int          n;
	int          r;
	localparam logic [FUNC_W-1:0] CODES [8] = '{FN_LOCK, FN_PULSE_WIDTH_OUT_ONE, FN_PULSE_WIDTH_OUT_TWO,
		FN_SIGDET, FN_US1, FN_US2, FN_EVLOG, FN_INTERRUPT_REQUEST_ONE};
	localparam logic [11:0] RA [5] = '{OFS_FUNC0, OFS_DIR, OFS_LVL, OFS_DIV,
		OFS_MASK};
	localparam logic [31:0] RV [5] = '{1, 32'h0000_FFFF, 0, 1, 0};
	gfs_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr,
		.freq_locked_loop_one_clk(fclk), .freq_locked_loop_one_lock(lv[0]),
		.pulse_width_out_one(lv[1]), .pulse_width_out_two(lv[2]),
		.signal_detect(lv[3]), .ultrasonic_detector_one(lv[4]),
		.ultrasonic_detector_two(lv[5]), .event_log_not_empty(lv[6]),
		.interrupt_request_one(lv[7]), .alarm_trigger(alm),
		.timer_done(tmr), .pin_in, .pin_out, .pin_oe, .irq);
	gfs_board u_board (.pin_out, .pin_oe, .pin_in);
	// ****
	// Tasks
	// ****
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		se = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// Counts high samples and rising edges of one pin
	task automatic meas(input int b, input int w);
		logic p;
		n = 0;
		r = 0;
		#1;
		p = pin_out[b];
		repeat (w) begin
			@(posedge pclk);
			#1;
			n += (pin_out[b] === 1'b1);
			r += (pin_out[b] === 1'b1 && p === 1'b0);
			p = pin_out[b];
		end
	endtask
	function automatic logic exp_lvl(int i, int h);
		return (h == 1 && i != 1 && i != 2) ? 1'b0 : lv[i];
	endfunction
	task automatic stop_test;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// ****
	// Clock and watchdog
	// ****
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	initial begin
		#200000;
		n_errors++;
		stop_test;
	end
	// ****
	// Tests
	// ****
	initial begin
		{presetn, psel, penable, pwrite, fclk, alm, tmr, lv} = '0;
		{paddr, pwdata, n_errors, n_tests} = '0;
		void'($urandom(66121));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			apb(0, RA[i], 0);
			chk(rd, RV[i]);
		end
		chk(pin_oe, 0);
		apb(0, 12'h05C, 0);
		chk(se, 1);
		chk(rd, 0);
		$display("[DONE] reset and map");
		for (int h = 0; h < 2; h++) for (int i = 0; i < 8; i++) begin
			apb(1, 12'(h * 32), 32'(CODES[i]));
			repeat (4) begin
				@(posedge pclk);
				lv <= 8'($urandom);
				repeat (2) @(posedge pclk);
				#1;
				chk(pin_out[h*8], exp_lvl(i, h));
				chk(pin_oe[h*8], 1);
			end
		end
		apb(1, OFS_FUNC0, 32'(FN_FLLCLK));
		apb(1, 12'h020, 32'(FN_FLLCLK));
		repeat (6) begin
			@(posedge pclk);
			fclk <= 1'($urandom);
			#1;
			chk(pin_out[0], fclk);
			chk({pin_oe[8], pin_out[8]}, 2'b10);
		end
		apb(1, OFS_DIV, 3);
		apb(1, OFS_FUNC0, 32'(FN_DERIVED_OUTPUT_CLOCK));
		meas(0, 24);
		chk(r, 4);
		$display("[DONE] pin routing");
		apb(1, OFS_FUNC0, 32'(FN_GPIO));
		apb(1, 12'h020, 32'(FN_GPIO));
		v = 16'($urandom);
		apb(1, OFS_LVL, 32'(v));
		apb(1, OFS_DIR, 0);
		repeat (2) @(posedge pclk);
		#1;
		chk({pin_oe, pin_out}, {16'hFFFF, v});
		apb(0, OFS_PIN_IN, 0);
		chk(rd, 32'(v));
		apb(1, OFS_DIR, 32'h0000_FFFF);
		apb(0, OFS_PIN_IN, 0);
		chk(rd, 0);
		$display("[DONE] level output");
		apb(1, OFS_DUR, 3);
		for (int k = 0; k < 4; k++) begin
			apb(1, 12'h004, 32'(FN_ALM1) + k);
			apb(1, OFS_MASK, (k == 3) ? 0 : 32'(1 << k));
			@(posedge pclk);
			alm <= 4'(1 << k);
			@(posedge pclk);
			alm <= 4'h0;
			meas(1, 8);
			chk(n, 3);
			chk(irq, k != 3);
			apb(0, OFS_STAT, 0);
			chk(rd, 32'(1 << k));
			apb(1, OFS_STAT, 32'(1 << k));
			#1;
			chk(irq, 0);
		end
		for (int t = 0; t < 2; t++) begin
			apb(1, 12'h008, 32'(FN_TMR1) + t);
			@(posedge pclk);
			tmr <= 2'(1 << t);
			@(posedge pclk);
			tmr <= 2'h0;
			meas(2, 6);
			chk(n, 1);
			apb(0, OFS_STAT, 0);
			chk(rd, 32'(1 << (4 + t)));
			apb(1, OFS_STAT, rd);
		end
		$display("[DONE] alarms and timers");
		stop_test;
	end
endmodule // gfs_top_tb
`default_nettype wire
